// ---- rtl/pll_feedback_lock.sv ----
// Module: PLL feedback A/B divider, path delays, digital lock detector, pin muxes
//
// Notes on behaviour
// - A equal to zero counts as zero, not as one.
// - With B bypassed, A is zero and division equals the prescaler ratio.
// - Dedicated and shared reset bits hold A/B in reset until cleared.
// - Enabled sync pin, low, resets reference, A and B counters; off by default.
// - Reference and feedback paths each have optional 3-bit delay.
// - Lock after programmed count of consecutive cycles under lock threshold.
// - Lock holds until one cycle exceeds the unlock threshold.
// - Unlock threshold wider than lock threshold gives hysteresis.
// - Window depends on range bit and antibacklash width; counter setting sets the cycle count.
// - Digital lock selectable on lock, status and reference monitor pins.
// - Analog lock offers n-channel and p-channel open-drain pulse modes.
// - Current-source mode releases the lock pin and sources current into it while locked, else drives it to ground.
// - Comparator output selectable for reference monitor and status pins.
// - Outputs flagged in enable-on-lock registers follow the charged indicator while the comparator is enabled, else stay off.
// - Dual modulus division is modulus times B plus A.
// - Fixed divide modes ignore A; division is prescaler times B.
`timescale 1ns/1ps
module pll_feedback_lock
  import pll_fb_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLOCK_ENABLE_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Clock paths
  input wire logic REF_EDGE_IN,
  input wire logic VCO_TICK_IN,
  input wire logic SYNC_N_IN,
  output logic REF_COUNTER_RESET_OUT,
  output logic FEEDBACK_EDGE_OUT,
  // Lock pin (open drain, enable low drives), comparator
  input wire logic LOCK_PIN_IN,
  output logic LOCK_PIN_OUT,
  output logic LOCK_PIN_OE_N_OUT,
  output logic CURRENT_SOURCE_ON_OUT,
  // Status pins
  output logic STATUS_PIN_OUT,
  output logic REFERENCE_MONITOR_PIN_OUT,
  output logic [15:0] OUTPUT_ENABLE_OUT
);

  // ==========================================================================
  // Registers
  divider_cfg_t div_cfg;
  delay_cfg_t delay_cfg;
  logic [31:0] lock_cfg;
  logic [31:0] pin_cfg;
  logic [15:0] out_en_mask;
  logic digital_lock_flag;
  logic charged_lock_indicator;
  logic [WIN_W-1:0] phase_diff;

  wire bus_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  wire bus_wr = bus_req && WB_WE_IN;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      WB_ACK_OUT <= 1'b0;
    end else if (CLOCK_ENABLE_IN) begin
      WB_ACK_OUT <= bus_req;
    end
  end

  // Reset bits are levels: they stay set until software clears them
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      div_cfg <= divider_cfg_t'(DIVIDER_RESET);
      delay_cfg <= '0;
      lock_cfg <= LOCK_CFG_RESET;
      pin_cfg <= PIN_CFG_RESET;
      out_en_mask <= '0;
    end else if (CLOCK_ENABLE_IN && bus_wr) begin
      unique case (WB_ADR_IN)
        ADDR_DIVIDER: div_cfg <= divider_cfg_t'(27'(merge(32'(div_cfg), WB_DAT_IN, WB_SEL_IN)));
        ADDR_DELAY: delay_cfg <= delay_cfg_t'(8'(merge(32'(delay_cfg), WB_DAT_IN, WB_SEL_IN)));
        ADDR_LOCK_CFG: lock_cfg <= merge(lock_cfg, WB_DAT_IN, WB_SEL_IN);
        ADDR_PIN_CFG: pin_cfg <= merge(pin_cfg, WB_DAT_IN, WB_SEL_IN);
        ADDR_OUT_ENABLE: out_en_mask <= 16'(merge(32'(out_en_mask), WB_DAT_IN, WB_SEL_IN));
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      WB_DAT_OUT <= '0;
    end else if (CLOCK_ENABLE_IN && bus_req) begin
      unique case (WB_ADR_IN)
        ADDR_DIVIDER: WB_DAT_OUT <= 32'(div_cfg);
        ADDR_DELAY: WB_DAT_OUT <= 32'(delay_cfg);
        ADDR_LOCK_CFG: WB_DAT_OUT <= lock_cfg;
        ADDR_PIN_CFG: WB_DAT_OUT <= pin_cfg;
        ADDR_OUT_ENABLE: WB_DAT_OUT <= 32'(out_en_mask);
        ADDR_STATUS: WB_DAT_OUT <= {22'h0, phase_diff, charged_lock_indicator, digital_lock_flag};
        default: WB_DAT_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Resets of the counters
  wire sync_reset = (div_cfg.sync_sel != 2'h0) && !SYNC_N_IN;
  wire ab_hold = div_cfg.ab_reset || div_cfg.shared_reset || sync_reset;
  assign REF_COUNTER_RESET_OUT = div_cfg.shared_reset || sync_reset;

  // ==========================================================================
  // Prescaler and A/B counters; VCO_TICK_IN is one input cycle per clock
  function automatic logic [5:0] modulus(input prescale_t p);
    unique case (p)
      PRESCALE_FD1: modulus = 6'h01;
      PRESCALE_FD2: modulus = 6'h02;
      PRESCALE_FD3: modulus = 6'h03;
      PRESCALE_DM2: modulus = 6'h02;
      PRESCALE_DM4: modulus = 6'h04;
      PRESCALE_DM8: modulus = 6'h08;
      PRESCALE_DM16: modulus = 6'h10;
      PRESCALE_DM32: modulus = 6'h20;
    endcase
  endfunction

  wire fixed_divide_mode = div_cfg.prescale inside {PRESCALE_FD1, PRESCALE_FD2, PRESCALE_FD3};
  logic [5:0] pre_count;
  logic [12:0] b_left;
  logic [5:0] a_left;
  logic fb_pulse;
  // A counter swallows one extra input cycle per prescaler pass (P+1)
  wire [5:0] pre_top = (!fixed_divide_mode && !div_cfg.b_bypass && a_left != 6'h00) ?
                       modulus(div_cfg.prescale) : 6'(modulus(div_cfg.prescale) - 6'h01);
  wire pre_wrap = VCO_TICK_IN && (pre_count == pre_top);
  wire [12:0] b_top = div_cfg.b_bypass ? 13'h0001 : div_cfg.b_count;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pre_count <= '0;
      b_left <= 13'h0001;
      a_left <= '0;
      fb_pulse <= 1'b0;
    end else if (CLOCK_ENABLE_IN) begin
      fb_pulse <= 1'b0;
      if (ab_hold) begin
        pre_count <= '0;
        b_left <= b_top;
        a_left <= fixed_divide_mode ? 6'h00 : div_cfg.a_count;
      end else if (pre_wrap) begin
        pre_count <= '0;
        if (a_left != 6'h00) begin
          a_left <= a_left - 6'h01;
        end
        if (b_left <= 13'h0001) begin
          b_left <= b_top;
          a_left <= (fixed_divide_mode || div_cfg.b_bypass) ? 6'h00 : div_cfg.a_count;
          fb_pulse <= 1'b1;
        end else begin
          b_left <= b_left - 13'h0001;
        end
      end else if (VCO_TICK_IN) begin
        pre_count <= pre_count + 6'h01;
      end
    end
  end

  // ==========================================================================
  // Path delays
  logic ref_delayed;
  logic fb_delayed;

  pll_delay_line ref_delay (
    .clk(CLOCK_IN),
    .rst_n(RESET_N_IN),
    .ce(CLOCK_ENABLE_IN),
    .enable(delay_cfg.delay_ref_en),
    .select(delay_cfg.delay_ref),
    .pulse_in(REF_EDGE_IN),
    .pulse_out(ref_delayed)
  );

  pll_delay_line fb_delay (
    .clk(CLOCK_IN),
    .rst_n(RESET_N_IN),
    .ce(CLOCK_ENABLE_IN),
    .enable(delay_cfg.delay_fb_en),
    .select(delay_cfg.delay_fb),
    .pulse_in(fb_pulse),
    .pulse_out(fb_delayed)
  );

  assign FEEDBACK_EDGE_OUT = fb_delayed;

  // ==========================================================================
  // Digital lock detector: measures edge separation in clocks
  // lock_cfg[1:0] antibacklash, [4] window range, [6:5] counter
  wire [WIN_W-1:0] lock_thr = WIN_W'({lock_cfg[4] ? 4'h1 : 4'h2, lock_cfg[1:0]} >> 1) + WIN_W'(1);
  wire [WIN_W-1:0] unlock_thr = WIN_W'(lock_thr << 1);
  // Nine bits: the longest count setting asks for 320 good cycles
  wire [8:0] needed = 9'h005 << (2 * lock_cfg[6:5]);

  logic measuring;
  logic [WIN_W-1:0] span;
  logic [8:0] good_count;
  wire edge_a = ref_delayed;
  wire edge_b = fb_delayed;

  // First edge of a pair opens the window, second closes it
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      measuring <= 1'b0;
      span <= '0;
      phase_diff <= '0;
      good_count <= '0;
      digital_lock_flag <= 1'b0;
    end else if (CLOCK_ENABLE_IN) begin
      if (edge_a && edge_b) begin
        measuring <= 1'b0;
        phase_diff <= '0;
      end else if (edge_a || edge_b) begin
        measuring <= !measuring;
        span <= '0;
        if (measuring) begin
          phase_diff <= span + WIN_W'(1);
        end
      end else if (measuring && span != '1) begin
        span <= span + WIN_W'(1);
      end
      if ((edge_a || edge_b) && (edge_a && edge_b || measuring)) begin
        if ((edge_a && edge_b) || span + WIN_W'(1) < lock_thr) begin
          if (good_count != 9'h1ff) begin
            good_count <= good_count + 9'h001;
          end
          if (good_count + 9'h001 >= needed) begin
            digital_lock_flag <= 1'b1;
          end
        end else begin
          good_count <= '0;
          if (span + WIN_W'(1) > unlock_thr) begin
            digital_lock_flag <= 1'b0;
          end
        end
      end else if (measuring && span >= unlock_thr) begin
        good_count <= '0;
        digital_lock_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Lock pin drivers and output routing
  wire [5:0] lock_sel = pin_cfg[5:0];
  wire [5:0] status_sel = pin_cfg[13:8];
  wire [4:0] reference_monitor_pin_sel = pin_cfg[20:16];
  wire comparator_en = pin_cfg[24];
  wire analog_pulse = edge_a ^ edge_b;
  wire current_mode = (lock_sel == LOCK_PIN_CURRENT_SOURCE);

  always_comb begin
    LOCK_PIN_OUT = 1'b0;
    LOCK_PIN_OE_N_OUT = 1'b1;
    CURRENT_SOURCE_ON_OUT = 1'b0;
    if (lock_sel == PIN_SEL_DIGITAL_LOCK) begin
      LOCK_PIN_OUT = digital_lock_flag;
      LOCK_PIN_OE_N_OUT = 1'b0;
    end else if (lock_sel == PIN_SEL_NCH_ANALOG) begin
      LOCK_PIN_OE_N_OUT = !analog_pulse;
    end else if (lock_sel == PIN_SEL_PCH_ANALOG) begin
      LOCK_PIN_OUT = 1'b1;
      LOCK_PIN_OE_N_OUT = !analog_pulse;
    end else if (current_mode) begin
      CURRENT_SOURCE_ON_OUT = digital_lock_flag;
      LOCK_PIN_OE_N_OUT = digital_lock_flag;
    end
  end

  // Comparator off reads as high, matching the holdover expectation
  assign charged_lock_indicator = comparator_en ? LOCK_PIN_IN : 1'b1;

  function automatic logic route(input logic [5:0] sel, input logic dl, input logic cmp);
    route = (sel == PIN_SEL_DIGITAL_LOCK) ? dl : (sel == PIN_SEL_COMPARATOR) ? cmp : 1'b0;
  endfunction

  assign STATUS_PIN_OUT = route(status_sel, digital_lock_flag, charged_lock_indicator);
  assign REFERENCE_MONITOR_PIN_OUT = route({1'b0, reference_monitor_pin_sel}, digital_lock_flag, charged_lock_indicator);
  // Gated without the clock: follows the indicator directly while the comparator is enabled, else held off
  assign OUTPUT_ENABLE_OUT = out_en_mask & {16{charged_lock_indicator && comparator_en}};

  // ==========================================================================
  // Checks
  lock_needs_count_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    $rose(digital_lock_flag) |-> $past(good_count) + 9'h001 >= $past(needed))
    else $error("lock raised before enough good cycles");
  hold_no_edge_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    $past(ab_hold) && ab_hold |-> !fb_pulse)
    else $error("feedback edge while counters held");
  sync_reset_ref_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    (div_cfg.sync_sel == 2'h0 && !div_cfg.shared_reset) |-> !REF_COUNTER_RESET_OUT)
    else $error("sync reset acted while disabled");
  current_source_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    current_mode |-> (CURRENT_SOURCE_ON_OUT == digital_lock_flag) && (LOCK_PIN_OE_N_OUT == digital_lock_flag))
    else $error("current source mode wrong");
  unlock_drop_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    $fell(digital_lock_flag) |-> $past(good_count) == 9'h000 || $past(span) + WIN_W'(1) > lock_thr)
    else $error("lock dropped without large error");
  hysteresis_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    unlock_thr > lock_thr)
    else $error("unlock threshold not wider");
  output_gate_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    !charged_lock_indicator |-> OUTPUT_ENABLE_OUT == 16'h0000)
    else $error("output enabled without lock indication");
  status_route_a: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    status_sel == PIN_SEL_DIGITAL_LOCK |-> STATUS_PIN_OUT == digital_lock_flag)
    else $error("status pin does not follow lock");
  lock_seen_c: cover property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN) $rose(digital_lock_flag));
  unlock_seen_c: cover property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN) $fell(digital_lock_flag));
  fb_edge_c: cover property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN) fb_pulse && !fixed_divide_mode);

endmodule

// ---- rtl/pll_fb_pkg.sv ----
// Package: constants and types for the PLL feedback divider and lock detector
package pll_fb_pkg;

  // ==========================================================================
  // Register map (word offsets as byte addresses)
  localparam logic [7:0] ADDR_DIVIDER = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_LOCK_CFG = 8'h08;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h0c;
  localparam logic [7:0] ADDR_OUT_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int B_LSB = 0;
  localparam int A_LSB = 13;
  localparam int PRESCALE_LSB = 19;
  localparam int AB_RESET_BIT = 22;
  localparam int SHARED_RESET_BIT = 23;
  localparam int SYNC_SEL_LSB = 24;
  localparam int B_BYPASS_BIT = 26;

  // ==========================================================================
  // Reset values and counts
  localparam logic [31:0] DIVIDER_RESET = 32'h0000_0003;
  localparam logic [31:0] LOCK_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] PIN_CFG_RESET = 32'h0000_0000;
  localparam logic [5:0] LOCK_PIN_CURRENT_SOURCE = 6'h04;
  localparam logic [5:0] PIN_SEL_DIGITAL_LOCK = 6'h01;
  localparam logic [5:0] PIN_SEL_NCH_ANALOG = 6'h02;
  localparam logic [5:0] PIN_SEL_PCH_ANALOG = 6'h03;
  localparam logic [5:0] PIN_SEL_COMPARATOR = 6'h05;
  localparam real CLOCK_MHZ = 50.0;
  localparam real DELAY_SPAN_NS = 1.0;
  localparam int DELAY_STEPS = 8;
  localparam int WIN_W = 8;

  typedef enum logic [2:0] {
    PRESCALE_FD1 = 3'b000,
    PRESCALE_FD2 = 3'b001,
    PRESCALE_DM2 = 3'b010,
    PRESCALE_DM4 = 3'b011,
    PRESCALE_DM8 = 3'b100,
    PRESCALE_DM16 = 3'b101,
    PRESCALE_DM32 = 3'b110,
    PRESCALE_FD3 = 3'b111
  } prescale_t;

  typedef struct packed {
    logic b_bypass;
    logic [1:0] sync_sel;
    logic shared_reset;
    logic ab_reset;
    prescale_t prescale;
    logic [5:0] a_count;
    logic [12:0] b_count;
  } divider_cfg_t;

  typedef struct packed {
    logic delay_ref_en;
    logic [2:0] delay_ref;
    logic delay_fb_en;
    logic [2:0] delay_fb;
  } delay_cfg_t;

endpackage

// ---- rtl/pll_delay_line.sv ----
// Module: programmable clock-cycle delay of an edge pulse
`timescale 1ns/1ps
module pll_delay_line
  import pll_fb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic [2:0] select,
  input wire logic pulse_in,
  output logic pulse_out
);

  logic [DELAY_STEPS-1:0] taps;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taps <= '0;
    end else if (ce) begin
      taps <= {taps[DELAY_STEPS-2:0], pulse_in};
    end
  end

  // Steps of one clock stand in for the sub-ns analog cell
  always_comb begin
    if (enable) begin
      pulse_out = taps[select];
    end else begin
      pulse_out = pulse_in;
    end
  end

endmodule

// ---- tb/pll_clock_partner.sv ----
// Partner model: reference divider output, VCO ticks and lock pin capacitor
`timescale 1ns/1ps
module pll_clock_partner
  import pll_fb_pkg::*;
#(
  parameter int CHARGE_CYCLES = 50
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bench controls
  input wire logic tick_en_in,
  input wire logic [5:0] offset_in,
  input wire logic pull_up_in,
  // Device side
  input wire logic fb_edge_in,
  input wire logic ref_reset_in,
  input wire logic pin_drive_in,
  input wire logic pin_oe_n_in,
  input wire logic source_on_in,
  output logic ref_edge_out,
  output logic vco_tick_out,
  output logic pin_level_out
);
  logic [63:0] history;
  int charge;

  // ==========================================================
  // Reference edges trail feedback edges by a chosen offset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      history <= '0;
    end else begin
      history <= {history[62:0], fb_edge_in};
    end
  end
  // Held reference divider gives no edges; offset kept below the period
  assign ref_edge_out = ref_reset_in ? 1'b0 : (offset_in == 6'h00 ? fb_edge_in : history[offset_in - 6'h01]);
  // One prescaler input cycle per clock at most keeps counters in range
  assign vco_tick_out = tick_en_in;

  // ==========================================================
  // Capacitor charges from the source, a driven pin empties it at once
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      charge <= 0;
    end else if (!source_on_in || !pin_oe_n_in) begin
      charge <= 0;
    end else if (charge < CHARGE_CYCLES) begin
      charge <= charge + 1;
    end
  end
  assign pin_level_out = !pin_oe_n_in ? pin_drive_in : (source_on_in ? (charge >= CHARGE_CYCLES) : pull_up_in);
endmodule

// ---- tb/tb_pll_feedback_divider_lock_detect.sv ----
// Self-checking bench for the feedback divider, delays and lock detector
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
module tb_pll_feedback_divider_lock_detect
  import pll_fb_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sync_n = 1'b1, tick_en = 1'b0, pull = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [5:0] offset = 6'h00;
  logic ack, ref_edge, vco_tick, ref_rst, fb, pin_drive, pin_oe_n, src_on, pin_level, stat_pin, mon_pin;
  logic [15:0] out_en;
  int num_errors = 0;
  int num_checks = 0;
  int n, c, lat0, lat5;

  pll_feedback_lock dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CLOCK_ENABLE_IN(1'b1), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .REF_EDGE_IN(ref_edge), .VCO_TICK_IN(vco_tick), .SYNC_N_IN(sync_n),
    .REF_COUNTER_RESET_OUT(ref_rst), .FEEDBACK_EDGE_OUT(fb), .LOCK_PIN_IN(pin_level), .LOCK_PIN_OUT(pin_drive),
    .LOCK_PIN_OE_N_OUT(pin_oe_n), .CURRENT_SOURCE_ON_OUT(src_on), .STATUS_PIN_OUT(stat_pin),
    .REFERENCE_MONITOR_PIN_OUT(mon_pin), .OUTPUT_ENABLE_OUT(out_en));
  pll_clock_partner #(.CHARGE_CYCLES(50)) partner (.clk_in(clk), .rst_n_in(rst_n), .tick_en_in(tick_en),
    .offset_in(offset), .pull_up_in(pull), .fb_edge_in(fb), .ref_reset_in(ref_rst), .pin_drive_in(pin_drive),
    .pin_oe_n_in(pin_oe_n), .source_on_in(src_on), .ref_edge_out(ref_edge), .vco_tick_out(vco_tick),
    .pin_level_out(pin_level));

  initial begin
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Closing report and bus tasks
  task automatic results();
    $display("Mismatches %0d, comparisons %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic timed_out();
    num_errors++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    results();
  endtask
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (ack !== 1'b1) timed_out();
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic set_div(input prescale_t p, input logic [5:0] a, input logic [12:0] b, input logic byp,
      input logic ab, input logic sh, input logic [1:0] sy);
    divider_cfg_t cfg;
    cfg = '{b_bypass: byp, sync_sel: sy, shared_reset: sh, ab_reset: ab, prescale: p, a_count: a, b_count: b};
    wb_cycle(1'b1, ADDR_DIVIDER, {5'h00, cfg});
  endtask

  // ==========================================================
  // Feedback edge helpers
  task automatic wait_fb(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 3000) timed_out();
    end while (fb !== 1'b1);
  endtask
  task automatic wait_periods(input int k);
    repeat (k) wait_fb(c);
  endtask
  task automatic check_ratio(input prescale_t p, input logic [5:0] a, input logic [12:0] b, input logic byp,
      input int exp);
    set_div(p, a, b, byp, 1'b0, 1'b0, 2'b00);
    wait_periods(3);
    `CHECK(c, exp, "feedback division ratio")
  endtask
  task automatic count_fb(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (fb === 1'b1) cnt++;
    end
  endtask
  task automatic latency(input logic [7:0] dly, output int cnt);
    tick_en <= 1'b0;
    wb_cycle(1'b1, ADDR_DELAY, {24'h0, dly});
    set_div(PRESCALE_FD1, 6'h00, 13'h0003, 1'b0, 1'b1, 1'b0, 2'b00);
    set_div(PRESCALE_FD1, 6'h00, 13'h0003, 1'b0, 1'b0, 1'b0, 2'b00);
    tick_en <= 1'b1;
    wait_fb(cnt);
  endtask
  task automatic check_lock(input logic exp);
    wb_cycle(1'b0, ADDR_STATUS, 32'h0);
    `CHECK(rd[0], exp, "digital lock flag")
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wb_cycle(1'b0, ADDR_DIVIDER, 32'h0);
    `CHECK(rd, DIVIDER_RESET, "divider reset value")
    wb_cycle(1'b0, ADDR_PIN_CFG, 32'h0);
    `CHECK(rd, PIN_CFG_RESET, "pin config reset value")
    wb_cycle(1'b0, ADDR_LOCK_CFG, 32'h0);
    `CHECK(rd, LOCK_CFG_RESET, "lock config reset value")
    wb_cycle(1'b1, 8'h20, 32'h5a5a_5a5a);
    wb_cycle(1'b0, 8'h20, 32'h0);
    `CHECK(rd, 32'h0, "unmapped address")
    wb_cycle(1'b1, ADDR_STATUS, 32'hffff_ffff);
    wb_cycle(1'b0, ADDR_STATUS, 32'h0);
    `CHECK(rd[1:0], 2'b10, "status is read only")
    tick_en <= 1'b1;
    check_ratio(PRESCALE_FD1, 6'h00, 13'h0003, 1'b0, 3);
    check_ratio(PRESCALE_FD2, 6'h02, 13'h0003, 1'b0, 6);
    check_ratio(PRESCALE_FD3, 6'h00, 13'h0004, 1'b0, 12);
    check_ratio(PRESCALE_DM2, 6'h01, 13'h0003, 1'b0, 7);
    check_ratio(PRESCALE_DM4, 6'h00, 13'h0003, 1'b0, 12);
    check_ratio(PRESCALE_DM8, 6'h06, 13'h0012, 1'b0, 150);
    check_ratio(PRESCALE_DM16, 6'h07, 13'h0009, 1'b0, 151);
    check_ratio(PRESCALE_DM32, 6'h06, 13'h0006, 1'b0, 198);
    check_ratio(PRESCALE_FD1, 6'h00, 13'h0001, 1'b1, 1);
    check_ratio(PRESCALE_FD3, 6'h00, 13'h0001, 1'b1, 3);
    check_ratio(PRESCALE_DM8, 6'h00, 13'h0001, 1'b1, 8);
    // Sync pin off, sync enabled, shared bit, own bit
    for (n = 0; n < 4; n++) begin
      @(posedge clk);
      sync_n <= (n < 2) ? 1'b0 : 1'b1;
      set_div(PRESCALE_FD1, 6'h00, 13'h0003, 1'b0, n == 3, n == 2, (n == 1) ? 2'b01 : 2'b00);
      count_fb(100, c);
      `CHECK(ref_rst, (n == 1 || n == 2), "reference counter reset")
      `CHECK(c == 0, n != 0, "feedback counters held")
    end
    sync_n <= 1'b1;
    check_ratio(PRESCALE_FD1, 6'h00, 13'h0003, 1'b0, 3);
    latency(8'h00, lat0);
    latency(8'h0d, lat5);
    `CHECK(lat5, lat0 + 6, "feedback delay enabled")
    latency(8'h05, lat5);
    `CHECK(lat5, lat0, "feedback delay disabled")
    // Period of 40 clocks stays longer than the unlock threshold
    set_div(PRESCALE_FD1, 6'h00, 13'h0028, 1'b0, 1'b0, 1'b0, 2'b00);
    for (n = 0; n < 4; n++) begin
      wb_cycle(1'b1, ADDR_LOCK_CFG, {25'h0, n[1:0], 5'h00});
      offset <= 6'h14;
      wait_periods(4);
      check_lock(1'b0);
      offset <= 6'h00;
      wait_periods((5 << (2 * n)) - 2);
      check_lock(1'b0);
      wait_periods(6);
      check_lock(1'b1);
    end
    wb_cycle(1'b1, ADDR_PIN_CFG, 32'h0001_0100);
    `CHECK({stat_pin, mon_pin}, 2'b11, "digital lock on pins")
    offset <= 6'h14;
    wait_periods(4);
    `CHECK({stat_pin, mon_pin}, 2'b00, "unlock on pins")
    wb_cycle(1'b1, ADDR_LOCK_CFG, 32'h0);
    offset <= 6'h00;
    wait_periods(10);
    pull <= 1'b1;
    wb_cycle(1'b1, ADDR_PIN_CFG, {26'h0, PIN_SEL_NCH_ANALOG});
    wait_fb(c);
    repeat (10) @(posedge clk);
    `CHECK(pin_level, 1'b1, "n-channel idle level")
    pull <= 1'b0;
    wb_cycle(1'b1, ADDR_PIN_CFG, {26'h0, PIN_SEL_PCH_ANALOG});
    wait_fb(c);
    repeat (10) @(posedge clk);
    `CHECK(pin_level, 1'b0, "p-channel idle level")
    wb_cycle(1'b1, ADDR_OUT_ENABLE, 32'h0000_00ff);
    wb_cycle(1'b1, ADDR_PIN_CFG, {26'h0, LOCK_PIN_CURRENT_SOURCE});
    `CHECK(out_en, 16'h0000, "outputs gated while comparator off")
    wb_cycle(1'b1, ADDR_PIN_CFG, 32'h0105_0504);
    `CHECK(src_on, 1'b1, "source on while locked")
    repeat (120) @(posedge clk);
    #1;
    `CHECK({out_en, stat_pin, mon_pin}, {16'h00ff, 2'b11}, "charged indicator")
    offset <= 6'h14;
    wait_periods(4);
    `CHECK({out_en, src_on, stat_pin}, {16'h0000, 2'b00}, "loss of lock discharges")
    results();
  end
endmodule
